// ===== gpmd_pkg.sv
package gpmd_pkg;

  // bus geometry
  localparam int GPMD_ADDR_W = 8;
  localparam int GPMD_DATA_W = 32;

  // register byte offsets
  localparam logic [7:0] GPMD_CTRL_OFS = 8'h00;
  localparam logic [7:0] GPMD_STATUS_OFS = 8'h04;

  // control register layout and reset value
  localparam int GPMD_CTRL_W = 12;
  localparam int GPMD_GAIN_LSB = 0;
  localparam int GPMD_PD_LSB = 4;
  localparam int GPMD_CAL_BIT = 7;
  localparam logic [11:0] GPMD_CTRL_RST = 12'h000;

  // status register layout
  localparam int GPMD_ST_PIN_MODE = 0;
  localparam int GPMD_ST_RESET = 1;
  localparam int GPMD_ST_ADC = 2;
  localparam int GPMD_ST_FAST = 3;
  localparam int GPMD_ST_LOWP = 4;
  localparam int GPMD_ST_REF = 5;
  localparam int GPMD_ST_CAL = 6;
  localparam int GPMD_ST_GAIN_CODE_LSB = 8;
  localparam int GPMD_ST_GAIN_VAL_LSB = 16;

  // power state codes
  localparam logic [2:0] GPMD_PD_ALL_OFF = 3'h0;
  localparam logic [2:0] GPMD_PD_ADC = 3'h1;
  localparam logic [2:0] GPMD_PD_FAST = 3'h2;
  localparam logic [2:0] GPMD_PD_LOWP = 3'h3;
  localparam logic [2:0] GPMD_PD_COMPS = 3'h4;
  localparam logic [2:0] GPMD_PD_ALL_ON = 3'h5;
  localparam logic [2:0] GPMD_PD_RESET = 3'h7;

  // gain codes
  localparam logic [3:0] GPMD_GAIN_REG_MODE = 4'h0;
  localparam logic [3:0] GPMD_GAIN_DEFAULT = 4'h1;
  localparam logic [3:0] GPMD_GAIN_RESERVED = 4'hf;

  // bus responses
  localparam logic [1:0] GPMD_RESP_OKAY = 2'h0;
  localparam logic [1:0] GPMD_RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    GPMD_MODE_REG = 3'h1,
    GPMD_MODE_PIN = 3'h2,
    GPMD_MODE_RST = 3'h4
  } gpmd_mode_t;

endpackage : gpmd_pkg

// ===== gpmd_sync.sv
`timescale 1ns/100ps
module gpmd_sync #(
  parameter int W = 1
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  // first stage feeds only the second stage
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= din;
      sync_q <= meta_q;
    end
  end

  assign dout = sync_q;
endmodule : gpmd_sync

// ===== gpmd_top.sv
// Overview of operation
// [R1] any gain-select pin high selects pin-driven mode
// [R2] all gain-select pins low selects register mode, gain from control register
// [R3] gain codes 0001..0111 give gains 1,2,3,4,6,8,12
// [R4] gain codes 1000..1110 give gains 16 up to 128, both amplifiers
// [R5] pin mode takes gain, power state, reference and calibration from pins
// [R6] power state comes from register or pins depending on mode
// [R7] power code 000 turns off all comparators and converters
// [R8] power code 101 turns on converters and all comparators
// [R9] codes 001,010,011,100 enable converters, fast pair, low-power pair, both pairs
// [R10] power code 111 resets only in pin-driven mode
// [R11] that reset clears registers and leaves everything powered down
// [R12] register mode after power-up: all off, gain 1 until written
// [R13] control bits 6..4 power code, bits 3..0 gain code
// [R14] gain code 1111 is reserved and keeps the applied gain
//
// The address map and the AXI4-Lite slave port are this design's own decisions.
`timescale 1ns/100ps
module gpmd_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [gpmd_pkg::GPMD_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [gpmd_pkg::GPMD_DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [gpmd_pkg::GPMD_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [gpmd_pkg::GPMD_DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [3:0] gain_select_pins,
  input wire logic [2:0] power_state_pins,
  input wire logic reference_source_select,
  input wire logic offset_cal_pin,
  output logic pin_mode,
  output logic [3:0] gain_code,
  output logic [7:0] gain_value,
  output logic adc_enable,
  output logic fast_comp_enable,
  output logic lowpower_comp_enable,
  output logic internal_ref_enable,
  output logic offset_cal_start,
  output logic device_reset
);
  import gpmd_pkg::*;

  typedef struct packed {
    logic awready;
    logic wready;
    logic aw_got;
    logic w_got;
    logic [GPMD_ADDR_W-1:0] waddr;
    logic [GPMD_DATA_W-1:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [GPMD_DATA_W-1:0] rdata;
    logic [1:0] rresp;
    logic [GPMD_CTRL_W-1:0] ctrl;
    gpmd_mode_t mode;
    logic [3:0] gain;
    logic [7:0] gain_val;
    logic adc_en;
    logic fast_en;
    logic lowp_en;
    logic ref_int;
    logic cal;
    logic pin_md;
    logic rst_md;
  } gpmd_state_t;

  localparam gpmd_state_t GPMD_STATE_RST = '{
    awready: 1'b0, wready: 1'b0, aw_got: 1'b0, w_got: 1'b0,
    waddr: '0, wdata: '0, wstrb: 4'h0, bvalid: 1'b0, bresp: GPMD_RESP_OKAY,
    arready: 1'b0, rvalid: 1'b0, rdata: '0, rresp: GPMD_RESP_OKAY,
    ctrl: GPMD_CTRL_RST, mode: GPMD_MODE_REG, gain: GPMD_GAIN_DEFAULT,
    gain_val: 8'h01, adc_en: 1'b0, fast_en: 1'b0, lowp_en: 1'b0,
    ref_int: 1'b0, cal: 1'b0, pin_md: 1'b0, rst_md: 1'b0
  };

  gpmd_state_t q;
  gpmd_state_t d;

  logic [3:0] gsel_s;
  logic [2:0] pd_s;
  logic ref_s;
  logic cal_s;

  // pins are asynchronous to aclk, so all pass the two-stage synchroniser
  gpmd_sync #(.W(9)) u_pin_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .din({gain_select_pins, power_state_pins, reference_source_select, offset_cal_pin}),
    .dout({gsel_s, pd_s, ref_s, cal_s})
  );

  function automatic logic [7:0] gpmd_gain_lut(input logic [3:0] code);
    logic [7:0] v;
    v = 8'h01;
    unique case (code)
      4'h1: v = 8'h01;
      4'h2: v = 8'h02;
      4'h3: v = 8'h03;
      4'h4: v = 8'h04;
      4'h5: v = 8'h06;
      4'h6: v = 8'h08;
      4'h7: v = 8'h0c;
      4'h8: v = 8'h10;
      4'h9: v = 8'h18;
      4'ha: v = 8'h20;
      4'hb: v = 8'h30;
      4'hc: v = 8'h40;
      4'hd: v = 8'h60;
      4'he: v = 8'h80;
      default: v = 8'h01;
    endcase
    return v;
  endfunction : gpmd_gain_lut

  // returns {adc, fast pair, low-power pair}
  function automatic logic [2:0] gpmd_pd_decode(input logic [2:0] code);
    logic [2:0] e;
    e = 3'h0;
    unique case (code)
      GPMD_PD_ADC: e = 3'h4;
      GPMD_PD_FAST: e = 3'h2;
      GPMD_PD_LOWP: e = 3'h1;
      GPMD_PD_COMPS: e = 3'h3;
      GPMD_PD_ALL_ON: e = 3'h7;
      // 000, 111 and the unlisted 110 keep everything off
      default: e = 3'h0;
    endcase
    return e;
  endfunction : gpmd_pd_decode

  logic pin_sel;
  logic [3:0] ctrl_gain;
  logic [2:0] ctrl_pd;
  assign pin_sel = |gsel_s;
  assign ctrl_gain = q.ctrl[GPMD_GAIN_LSB +: 4];
  assign ctrl_pd = q.ctrl[GPMD_PD_LSB +: 3];

  always_comb begin
    logic [2:0] en;
    logic [GPMD_DATA_W-1:0] status;
    en = 3'h0;
    status = '0;
    d = q;

    // write channel: address and data accepted in either order
    if (s_axi_awvalid && q.awready) begin
      d.aw_got = 1'b1;
      d.waddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && q.wready) begin
      d.w_got = 1'b1;
      d.wdata = s_axi_wdata;
      d.wstrb = s_axi_wstrb;
    end
    if (s_axi_bvalid && s_axi_bready) begin
      d.bvalid = 1'b0;
    end
    if (d.aw_got && d.w_got && !q.bvalid) begin
      d.aw_got = 1'b0;
      d.w_got = 1'b0;
      d.bvalid = 1'b1;
      if (d.waddr == GPMD_CTRL_OFS) begin
        d.bresp = GPMD_RESP_OKAY;
        if (d.wstrb[0]) begin
          d.ctrl[7:0] = d.wdata[7:0];
        end
        if (d.wstrb[1]) begin
          d.ctrl[11:8] = d.wdata[11:8];
        end
      end else if (d.waddr == GPMD_STATUS_OFS) begin
        // status is read-only; writes are dropped without error
        d.bresp = GPMD_RESP_OKAY;
      end else begin
        d.bresp = GPMD_RESP_SLVERR;
      end
    end
    d.awready = !d.aw_got && !d.bvalid;
    d.wready = !d.w_got && !d.bvalid;

    // read channel
    status[GPMD_ST_PIN_MODE] = (q.mode != GPMD_MODE_REG);
    status[GPMD_ST_RESET] = (q.mode == GPMD_MODE_RST);
    status[GPMD_ST_ADC] = q.adc_en;
    status[GPMD_ST_FAST] = q.fast_en;
    status[GPMD_ST_LOWP] = q.lowp_en;
    status[GPMD_ST_REF] = q.ref_int;
    status[GPMD_ST_CAL] = q.cal;
    status[GPMD_ST_GAIN_CODE_LSB +: 4] = q.gain;
    status[GPMD_ST_GAIN_VAL_LSB +: 8] = q.gain_val;
    if (s_axi_rvalid && s_axi_rready) begin
      d.rvalid = 1'b0;
    end
    if (s_axi_arvalid && q.arready) begin
      d.rvalid = 1'b1;
      d.rresp = GPMD_RESP_OKAY;
      if (s_axi_araddr == GPMD_CTRL_OFS) begin
        d.rdata = {{(GPMD_DATA_W-GPMD_CTRL_W){1'b0}}, q.ctrl};
      end else if (s_axi_araddr == GPMD_STATUS_OFS) begin
        d.rdata = status;
      end else begin
        d.rdata = '0;
        d.rresp = GPMD_RESP_SLVERR;
      end
    end
    d.arready = !d.rvalid;

    // configuration decode
    if (pin_sel && pd_s == GPMD_PD_RESET) begin
      // [R10] pin-mode reset
      d.mode = GPMD_MODE_RST;
      // [R11] clear and power down; overrides a write landing in the same cycle
      d.ctrl = GPMD_CTRL_RST;
      d.gain = GPMD_GAIN_DEFAULT;
      d.cal = 1'b0;
      en = 3'h0;
    end else if (pin_sel) begin
      // [R1] pin-driven mode
      d.mode = GPMD_MODE_PIN;
      // [R5] gain and calibration from pins
      if (gsel_s != GPMD_GAIN_RESERVED) begin
        d.gain = gsel_s;
      end
      d.cal = cal_s;
      // [R6] power state from pins
      en = gpmd_pd_decode(pd_s);
    end else begin
      // [R2] register mode
      d.mode = GPMD_MODE_REG;
      // [R12] cleared register means gain 1
      if (ctrl_gain == GPMD_GAIN_REG_MODE) begin
        d.gain = GPMD_GAIN_DEFAULT;
      // [R14] reserved code holds gain
      end else if (ctrl_gain != GPMD_GAIN_RESERVED) begin
        d.gain = ctrl_gain;
      end
      d.cal = q.ctrl[GPMD_CAL_BIT];
      // [R13] power code from bits 6..4, 111 just powers down here
      en = gpmd_pd_decode(ctrl_pd);
    end
    // [R3] [R4] gain lookup
    d.gain_val = gpmd_gain_lut(d.gain);
    // [R7] [R8] [R9] power decode
    d.adc_en = en[2];
    d.fast_en = en[1];
    d.lowp_en = en[0];
    // reference select is a pin in either mode
    d.ref_int = ref_s;
    // mode flags get their own flops so the pins see no decode logic
    d.pin_md = (d.mode != GPMD_MODE_REG);
    d.rst_md = (d.mode == GPMD_MODE_RST);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= GPMD_STATE_RST;
    end else begin
      q <= d;
    end
  end

  assign s_axi_awready = q.awready;
  assign s_axi_wready = q.wready;
  assign s_axi_bresp = q.bresp;
  assign s_axi_bvalid = q.bvalid;
  assign s_axi_arready = q.arready;
  assign s_axi_rdata = q.rdata;
  assign s_axi_rresp = q.rresp;
  assign s_axi_rvalid = q.rvalid;
  assign pin_mode = q.pin_md;
  assign gain_code = q.gain;
  assign gain_value = q.gain_val;
  assign adc_enable = q.adc_en;
  assign fast_comp_enable = q.fast_en;
  assign lowpower_comp_enable = q.lowp_en;
  assign internal_ref_enable = q.ref_int;
  assign offset_cal_start = q.cal;
  assign device_reset = q.rst_md;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  AST_PIN_MODE: assert property (pin_sel |=> pin_mode) // [R1]
    else $error("pin mode not entered with a gain pin high");

  AST_REG_GAIN: assert property ( // [R2]
    (!pin_sel && ctrl_gain != GPMD_GAIN_REG_MODE && ctrl_gain != GPMD_GAIN_RESERVED)
    |=> (!pin_mode && gain_code == $past(ctrl_gain)))
    else $error("register mode gain not taken from control register");

  AST_GAIN_LOW: assert property ( // [R3]
    (pin_sel && pd_s != GPMD_PD_RESET && gsel_s == 4'h7) |=> gain_value == 8'h0c)
    else $error("gain code 0111 did not give gain 12");

  AST_GAIN_HIGH: assert property ( // [R4]
    (pin_sel && pd_s != GPMD_PD_RESET && gsel_s == 4'he) |=> gain_value == 8'h80)
    else $error("gain code 1110 did not give gain 128");

  AST_PIN_SOURCES: assert property ( // [R5]
    (pin_sel && pd_s != GPMD_PD_RESET) |=> (offset_cal_start == $past(cal_s)
      && internal_ref_enable == $past(ref_s)))
    else $error("pin mode calibration or reference not from pins");

  AST_PD_SOURCE: assert property ( // [R6]
    (!pin_sel && ctrl_pd == GPMD_PD_ALL_ON) ##1 (pin_sel && pd_s == GPMD_PD_ALL_OFF)
    |=> !adc_enable && !fast_comp_enable && !lowpower_comp_enable)
    else $error("power state not switched to pins");

  AST_PD_OFF: assert property ( // [R7]
    (pin_sel && pd_s == GPMD_PD_ALL_OFF) |=> !adc_enable && !fast_comp_enable && !lowpower_comp_enable)
    else $error("code 000 left something powered");

  AST_PD_ON: assert property ( // [R8]
    (pin_sel && pd_s == GPMD_PD_ALL_ON) |=> adc_enable && fast_comp_enable && lowpower_comp_enable)
    else $error("code 101 did not power everything");

  AST_PD_FAST: assert property ( // [R9]
    (pin_sel && pd_s == GPMD_PD_FAST) |=> !adc_enable && fast_comp_enable && !lowpower_comp_enable)
    else $error("code 010 did not select only the fast pair");

  AST_PD_COMPS: assert property ( // [R9]
    (pin_sel && pd_s == GPMD_PD_COMPS) |=> !adc_enable && fast_comp_enable && lowpower_comp_enable)
    else $error("code 100 did not select both pairs only");

  AST_NO_REG_RESET: assert property ( // [R10]
    (!pin_sel && ctrl_pd == GPMD_PD_RESET) |=> !device_reset && !adc_enable)
    else $error("code 111 reset the device in register mode");

  AST_RESET_CLEAR: assert property ( // [R11]
    (pin_sel && pd_s == GPMD_PD_RESET) |=> (device_reset && q.ctrl == GPMD_CTRL_RST
      && !adc_enable && !fast_comp_enable && !lowpower_comp_enable))
    else $error("pin reset did not clear and power down");

  AST_POWERUP: assert property ( // [R12]
    (!pin_sel && q.ctrl == GPMD_CTRL_RST) |=> gain_value == 8'h01 && !adc_enable && !fast_comp_enable)
    else $error("cleared register mode not gain 1 and off");

  AST_REG_PD: assert property ( // [R13]
    (!pin_sel && ctrl_pd == GPMD_PD_LOWP) |=> !adc_enable && !fast_comp_enable && lowpower_comp_enable)
    else $error("register power bits not decoded");

  AST_RESERVED_GAIN: assert property ( // [R14]
    (pin_sel && pd_s != GPMD_PD_RESET && gsel_s == GPMD_GAIN_RESERVED) |=> $stable(gain_code))
    else $error("reserved gain code changed the gain");

endmodule : gpmd_top

// ===== gpmd_pin_host.sv
`timescale 1ns/100ps
module gpmd_pin_host (
  output logic [3:0] gain_select_pins,
  output logic [2:0] power_state_pins,
  output logic reference_source_select,
  output logic offset_cal_pin
);
  // strapped low at power-up, so the device starts in register mode
  initial begin
    gain_select_pins = 4'h0;
    power_state_pins = 3'h0;
    reference_source_select = 1'b0;
    offset_cal_pin = 1'b0;
  end

  // caller sits on a rising edge; levels then hold until the next call
  task automatic drive(input logic [3:0] g, input logic [2:0] p, input logic r, input logic c);
    gain_select_pins <= g;
    power_state_pins <= p;
    reference_source_select <= r;
    offset_cal_pin <= c;
  endtask : drive
endmodule : gpmd_pin_host

// ===== tb_gpmd_top.sv
`timescale 1ns/100ps
module tb_gpmd_top;
  import gpmd_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [3:0] gain_select_pins, gain_code;
  logic [2:0] power_state_pins;
  logic reference_source_select, offset_cal_pin, pin_mode, adc_enable, fast_comp_enable;
  logic lowpower_comp_enable, internal_ref_enable, offset_cal_start, device_reset;
  logic [7:0] gain_value;
  logic [31:0] rd;
  logic [1:0] rs;
  logic [3:0] g;
  logic [2:0] p3;
  logic r, c;
  int err_count = 0;
  int tests_run = 0;
  logic [7:0] gain_tab [16] = '{8'h01, 8'h01, 8'h02, 8'h03, 8'h04, 8'h06, 8'h08, 8'h0c,
                                8'h10, 8'h18, 8'h20, 8'h30, 8'h40, 8'h60, 8'h80, 8'h00};

  always #5 aclk = ~aclk;

  gpmd_pin_host gpmd_pin_host_inst (.gain_select_pins(gain_select_pins), .power_state_pins(power_state_pins),
    .reference_source_select(reference_source_select), .offset_cal_pin(offset_cal_pin));

  gpmd_top gpmd_top_inst (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .gain_select_pins(gain_select_pins), .power_state_pins(power_state_pins),
    .reference_source_select(reference_source_select), .offset_cal_pin(offset_cal_pin),
    .pin_mode(pin_mode), .gain_code(gain_code), .gain_value(gain_value), .adc_enable(adc_enable),
    .fast_comp_enable(fast_comp_enable), .lowpower_comp_enable(lowpower_comp_enable),
    .internal_ref_enable(internal_ref_enable), .offset_cal_start(offset_cal_start),
    .device_reset(device_reset));

  function automatic logic [2:0] en_of(input logic [2:0] pd);
    case (pd)
      3'h1: return 3'b001;
      3'h2: return 3'b010;
      3'h3: return 3'b100;
      3'h4: return 3'b110;
      3'h5: return 3'b111;
      default: return 3'b000;
    endcase
  endfunction : en_of

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR t=%0t value %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // ready/valid sampled at the falling edge, so they equal what the next rising edge takes
  task automatic bus(input bit wr, input logic [7:0] a, input logic [31:0] d);
    bit aw_t, w_t, ar_t, done;
    aw_t = 1'b0;
    w_t = 1'b0;
    ar_t = 1'b0;
    done = 1'b0;
    if (wr) begin
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
    end else begin
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
    end
    while (!done) begin
      @(negedge aclk);
      if (s_axi_awvalid && s_axi_awready) aw_t = 1'b1;
      if (s_axi_wvalid && s_axi_wready) w_t = 1'b1;
      if (s_axi_arvalid && s_axi_arready) ar_t = 1'b1;
      if (wr ? s_axi_bvalid : s_axi_rvalid) begin
        done = 1'b1;
        rs = wr ? s_axi_bresp : s_axi_rresp;
        rd = s_axi_rdata;
      end
      @(posedge aclk);
      if (aw_t) s_axi_awvalid <= 1'b0;
      if (w_t) s_axi_wvalid <= 1'b0;
      if (ar_t) s_axi_arvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
    s_axi_rready <= 1'b0;
    // one idle edge so a following call never reassigns a ready in this time step
    @(posedge aclk);
  endtask : bus

  task automatic check_out(input logic pm, input logic [3:0] gc, input logic [2:0] pd, input logic rf, input logic cl);
    @(negedge aclk);
    chk(32'(pin_mode), 32'(pm));
    chk(32'(gain_code), 32'(gc));
    chk(32'(gain_value), 32'(gain_tab[gc]));
    chk(32'({lowpower_comp_enable, fast_comp_enable, adc_enable}), 32'(en_of(pd)));
    chk(32'(internal_ref_enable), 32'(rf));
    chk(32'(offset_cal_start), 32'(cl));
    @(posedge aclk);
  endtask : check_out

  task automatic tally_and_finish();
    $display("mismatches %0d of %0d checks", err_count, tests_run);
    if (err_count == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : tally_and_finish

  initial begin
    repeat (20000) @(posedge aclk);
    err_count++;
    tally_and_finish();
  end

  initial begin
    void'($urandom(32));
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (4) @(posedge aclk);
    check_out(1'b0, 4'h1, 3'h0, 1'b0, 1'b0);
    bus(1'b0, GPMD_CTRL_OFS, 32'h0);
    chk(rd, 32'h0);
    // every power code from the register, power-state and calibration pins left noisy to prove they are ignored
    for (int p = 0; p < 8; p++) begin
      g = 4'(1 + $urandom % 14);
      c = 1'($urandom);
      r = 1'($urandom);
      gpmd_pin_host_inst.drive(4'h0, 3'($urandom % 8), r, 1'($urandom));
      bus(1'b1, GPMD_CTRL_OFS, {24'h0, c, 3'(p), g});
      chk(32'(rs), 32'(GPMD_RESP_OKAY));
      repeat (4) @(posedge aclk);
      check_out(1'b0, g, 3'(p), r, c);
      chk(32'(device_reset), 32'h0);
      bus(1'b0, GPMD_STATUS_OFS, 32'h0);
      chk(32'(rd[23:16]), 32'(gain_tab[g]));
    end
    bus(1'b1, GPMD_CTRL_OFS, 32'h0000005f);
    repeat (2) @(posedge aclk);
    check_out(1'b0, g, 3'h5, r, 1'b0);
    // corner: register mode all on, then pins take over with code 000
    gpmd_pin_host_inst.drive(4'h1, 3'h0, r, 1'b0);
    repeat (4) @(posedge aclk);
    check_out(1'b1, 4'h1, 3'h0, r, 1'b0);
    for (int k = 1; k < 15; k++) begin
      p3 = 3'($urandom % 7);
      r = 1'($urandom);
      c = 1'($urandom);
      gpmd_pin_host_inst.drive(4'(k), p3, r, c);
      repeat (4) @(posedge aclk);
      check_out(1'b1, 4'(k), p3, r, c);
    end
    gpmd_pin_host_inst.drive(4'hf, 3'h5, r, 1'b0);
    repeat (4) @(posedge aclk);
    check_out(1'b1, 4'he, 3'h5, r, 1'b0);
    bus(1'b1, GPMD_CTRL_OFS, 32'h000000a5);
    gpmd_pin_host_inst.drive(4'h3, 3'h7, r, 1'b0);
    repeat (4) @(posedge aclk);
    chk(32'(device_reset), 32'h1);
    chk(32'({pin_mode, lowpower_comp_enable, fast_comp_enable, adc_enable}), 32'h8);
    bus(1'b0, GPMD_CTRL_OFS, 32'h0);
    chk(rd, 32'h0);
    gpmd_pin_host_inst.drive(4'h0, 3'h0, r, 1'b0);
    repeat (4) @(posedge aclk);
    check_out(1'b0, 4'h1, 3'h0, r, 1'b0);
    bus(1'b0, 8'h08, 32'h0);
    chk(32'(rs), 32'(GPMD_RESP_SLVERR));
    chk(rd, 32'h0);
    bus(1'b1, 8'h0c, 32'h5);
    chk(32'(rs), 32'(GPMD_RESP_SLVERR));
    bus(1'b1, GPMD_STATUS_OFS, 32'h5);
    chk(32'(rs), 32'(GPMD_RESP_OKAY));
    tally_and_finish();
  end
endmodule : tb_gpmd_top
